// ==== hw/scec_pkg.sv ====
// constants, field layouts and types shared by the setup and comm error checker
package scec_pkg;

  // register byte offsets
  localparam logic [7:0] REG_SRC = 8'h00;
  localparam logic [7:0] REG_OUT = 8'h04;
  localparam logic [7:0] REG_PID_A = 8'h08;
  localparam logic [7:0] REG_PID_B = 8'h0C;
  localparam logic [7:0] REG_INPUT = 8'h10;
  localparam logic [7:0] REG_ALARM = 8'h14;
  localparam logic [7:0] REG_SETUP_ERR = 8'h18;
  localparam logic [7:0] REG_COMM_ERR = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;

  // field positions
  localparam int SRC_PV_LSB = 0;
  localparam int SRC_SP_LSB = 4;
  localparam int OUT_DIRECT_BIT = 0;
  localparam int OUT_ROLE_LSB = 4;
  localparam int PID_PB_LSB = 0;
  localparam int PID_TI_LSB = 16;
  localparam int IN_U1_LSB = 0;
  localparam int IN_U2_LSB = 4;
  localparam int IN_DP1_LSB = 8;
  localparam int IN_DP2_LSB = 12;
  localparam int ALM_A1_LSB = 0;
  localparam int ALM_A2_LSB = 8;
  localparam int IRQ_SETUP_BIT = 0;
  localparam int IRQ_COMM_BIT = 1;

  // source selections for process value and setpoint
  localparam logic [2:0] SRC_IN1 = 3'h0;
  localparam logic [2:0] SRC_IN2 = 3'h1;
  localparam logic [2:0] SRC_1M2 = 3'h2;
  localparam logic [2:0] SRC_2M1 = 3'h3;
  localparam logic [2:0] SRC_LOCAL = 3'h4;

  // secondary output roles
  localparam logic [1:0] ROLE_NONE = 2'h0;
  localparam logic [1:0] ROLE_COOL = 2'h1;
  localparam logic [1:0] ROLE_ALARM2 = 2'h2;

  // alarm functions; codes with bit 3 set combine both inputs
  localparam logic [3:0] ALM_NONE = 4'h0;
  localparam logic [3:0] ALM_DWELL = 4'h1;
  localparam int ALM_DIFF_BIT = 3;

  // error codes
  localparam logic [5:0] ERR_NONE = 6'h00;
  localparam logic [5:0] ERR_PV_SP_IN1 = 6'h01;
  localparam logic [5:0] ERR_PV_SP_IN2 = 6'h02;
  localparam logic [5:0] ERR_DEPENDENT = 6'h03;
  localparam logic [5:0] ERR_COOLING = 6'h04;
  localparam logic [5:0] ERR_UNIT_MISMATCH = 6'h05;
  localparam logic [5:0] ERR_ALARM2_NONE = 6'h06;
  localparam logic [5:0] ERR_DWELL_BOTH = 6'h07;
  localparam logic [5:0] ERR_BAD_FUNC = 6'h0A;
  localparam logic [5:0] ERR_ADDR_RANGE = 6'h0B;
  localparam logic [5:0] ERR_NO_PARAM = 6'h0C;
  localparam logic [5:0] ERR_READ_ONLY = 6'h0E;
  localparam logic [5:0] ERR_DATA_RANGE = 6'h0F;

  // host function codes
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;

  // parameter table
  localparam int ATTR_AW = 6;
  localparam logic [15:0] ADDR_LIMIT = 16'h0040;
  localparam logic [5:0] TBL_HOLE_A = 6'h0D;
  localparam logic [5:0] TBL_HOLE_B = 6'h0E;
  localparam logic [5:0] TBL_RO_FIRST = 6'h30;
  localparam logic [5:0] TBL_LIMIT_SPLIT = 6'h08;
  localparam logic [15:0] TBL_MIN = 16'h0000;
  localparam logic [15:0] TBL_MAX_LOW = 16'h0FFF;
  localparam logic [15:0] TBL_MAX_HIGH = 16'h270F;

  // values after reset
  localparam logic [2:0] RST_PV_SRC = SRC_IN1;
  localparam logic [2:0] RST_SP_SRC = SRC_LOCAL;
  localparam logic [15:0] RST_PB = 16'h0064;
  localparam logic [15:0] RST_TI = 16'h00C8;

  typedef enum logic [2:0] {
    SCEC_IDLE = 3'b001,
    SCEC_LOOKUP = 3'b010,
    SCEC_EVAL = 3'b100
  } scec_fsm_t;

endpackage

// ==== hw/scec_attr_if.sv ====
// lookup channel between the request checker and the parameter table
`timescale 1ns/1ps
interface scec_attr_if;
  logic [scec_pkg::ATTR_AW-1:0] addr;
  logic present;
  logic read_only;
  logic [15:0] min_val;
  logic [15:0] max_val;
  modport lookup (output addr, input present, input read_only, input min_val, input max_val);
  modport store (input addr, output present, output read_only, output min_val, output max_val);
endinterface

// ==== hw/scec_attr_rom.sv ====
// parameter attribute table with registered read data
`timescale 1ns/1ps
module scec_attr_rom #(
  parameter int DEPTH = 64
) (
  input logic i_clk,
  input logic i_arst_n,
  scec_attr_if.store tbl
);

  typedef struct packed {
    logic present;
    logic read_only;
    logic [15:0] min_val;
    logic [15:0] max_val;
  } scec_attr_t;

  scec_attr_t q;
  scec_attr_t d;

  function automatic scec_attr_t attr_of(input logic [scec_pkg::ATTR_AW-1:0] idx);
    scec_attr_t a;
    a.present = (32'(idx) < DEPTH) && (idx != scec_pkg::TBL_HOLE_A) &&
                (idx != scec_pkg::TBL_HOLE_B);
    a.read_only = (idx >= scec_pkg::TBL_RO_FIRST);
    a.min_val = scec_pkg::TBL_MIN;
    a.max_val = (idx < scec_pkg::TBL_LIMIT_SPLIT) ? scec_pkg::TBL_MAX_LOW :
                scec_pkg::TBL_MAX_HIGH;
    return a;
  endfunction

  always_comb
  begin
    d = attr_of(tbl.addr);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tbl.present = q.present;
  assign tbl.read_only = q.read_only;
  assign tbl.min_val = q.min_val;
  assign tbl.max_val = q.max_val;

endmodule

// ==== hw/scec_checker.sv ====
// setup consistency and host request checker with display and register bank
// How it works
// - error 1: both sources select input one
// - error 2: both sources select input two
// - error 3: difference value against direct setpoint
// - error 4: bad cooling or no PID terms
// - error 5: combined inputs with unit mismatch
// - error 6: alarm-two role without alarm function
// - no alarm drive then on secondary output
// - error 7: dwell timer on both alarms
// - comm error 10: unsupported function code
// - comm error 11: address beyond implemented range
// - comm error 12: parameter not present
// - comm error 14: refuse read-only writes
// - show active error code on display
// - comm error 15: refuse out-of-range data
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module scec_checker (
  input logic i_clk,
  input logic i_arst_n,
  input logic [7:0] i_avs_address,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input logic i_req_valid,
  input logic i_req_write,
  input logic [7:0] i_req_func,
  input logic [15:0] i_req_addr,
  input logic [15:0] i_req_data,
  output logic o_req_ready,
  output logic o_resp_valid,
  output logic [5:0] o_resp_code,
  output logic o_wr_en,
  output logic [15:0] o_wr_addr,
  output logic [15:0] o_wr_data,
  input logic i_alarm2_trip,
  output logic o_secondary_alarm,
  output logic o_disp_error,
  output logic [3:0] o_disp_tens,
  output logic [3:0] o_disp_ones,
  output logic o_irq
);

  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    logic [2:0] pv_src;
    logic [2:0] sp_src;
    logic direct;
    logic [1:0] role;
    logic [15:0] pb_a;
    logic [15:0] ti_a;
    logic [15:0] pb_b;
    logic [15:0] ti_b;
    logic [3:0] unit1;
    logic [3:0] unit2;
    logic [3:0] dp1;
    logic [3:0] dp2;
    logic [3:0] first_alarm_function;
    logic [3:0] second_alarm_function;
    logic [5:0] setup_err;
    logic [5:0] comm_err;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    scec_pkg::scec_fsm_t fsm;
    logic req_write;
    logic [7:0] req_func;
    logic [15:0] req_addr;
    logic [15:0] req_data;
    logic ready;
    logic resp_valid;
    logic [5:0] resp_code;
    logic wr_en;
    logic [15:0] wr_addr;
    logic [15:0] wr_data;
    logic sec_alarm;
    logic disp_err;
    logic [3:0] tens;
    logic [3:0] ones;
    logic irq;
  } scec_state_t;

  scec_state_t q;
  scec_state_t d;

  scec_attr_if attr ();

  scec_attr_rom #(
    .DEPTH(int'(scec_pkg::ADDR_LIMIT))
  ) u_rom (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .tbl(attr.store)
  );

  assign attr.addr = q.req_addr[scec_pkg::ATTR_AW-1:0];

  function automatic logic is_diff_src(input logic [2:0] s);
    return (s == scec_pkg::SRC_1M2) || (s == scec_pkg::SRC_2M1);
  endfunction

  function automatic logic is_direct_src(input logic [2:0] s);
    return (s == scec_pkg::SRC_IN1) || (s == scec_pkg::SRC_IN2);
  endfunction

  // lowest code wins when several setup faults coexist
  function automatic logic [5:0] check_setup(input scec_state_t s);
    logic mismatch;
    logic combined;
    mismatch = (s.unit1 != s.unit2) || (s.dp1 != s.dp2);
    combined = is_diff_src(s.pv_src) || is_direct_src(s.sp_src) ||
               s.first_alarm_function[scec_pkg::ALM_DIFF_BIT] || s.second_alarm_function[scec_pkg::ALM_DIFF_BIT];
    if (s.pv_src == scec_pkg::SRC_IN1 && s.sp_src == scec_pkg::SRC_IN1)
      return scec_pkg::ERR_PV_SP_IN1;
    if (s.pv_src == scec_pkg::SRC_IN2 && s.sp_src == scec_pkg::SRC_IN2)
      return scec_pkg::ERR_PV_SP_IN2;
    if (is_diff_src(s.pv_src) && is_direct_src(s.sp_src))
      return scec_pkg::ERR_DEPENDENT;
    if ((s.role == scec_pkg::ROLE_COOL && s.direct) ||
        ((s.pb_a == 16'h0000 || s.pb_b == 16'h0000) &&
         (s.ti_a == 16'h0000 || s.ti_b == 16'h0000)))
      return scec_pkg::ERR_COOLING;
    if (mismatch && combined)
      return scec_pkg::ERR_UNIT_MISMATCH;
    if (s.role == scec_pkg::ROLE_ALARM2 && s.second_alarm_function == scec_pkg::ALM_NONE)
      return scec_pkg::ERR_ALARM2_NONE;
    if (s.first_alarm_function == scec_pkg::ALM_DWELL && s.second_alarm_function == scec_pkg::ALM_DWELL)
      return scec_pkg::ERR_DWELL_BOTH;
    return scec_pkg::ERR_NONE;
  endfunction

  // codes stay below 64, so two decimal digits suffice
  function automatic logic [7:0] to_bcd(input logic [5:0] code);
    logic [5:0] t;
    t = code / 6'd10;
    return {t[3:0], 4'(code - 6'(t * 6'd10))};
  endfunction

  always_comb
  begin
    logic [31:0] rd;
    logic [5:0] code;
    logic [5:0] shown;
    logic [1:0] set_ev;
    logic [1:0] clr_ev;
    logic comm_clr;
    logic [7:0] bcd;
    rd = 32'h0000_0000;
    code = scec_pkg::ERR_NONE;
    shown = scec_pkg::ERR_NONE;
    set_ev = 2'h0;
    clr_ev = 2'h0;
    comm_clr = 1'b0;
    bcd = 8'h00;
    d = q;
    d.resp_valid = 1'b0;
    d.wr_en = 1'b0;

    // register bus: one wait cycle, then the access completes
    case (i_avs_address)
      scec_pkg::REG_SRC:
        rd = 32'({q.sp_src, 1'b0, q.pv_src}) << scec_pkg::SRC_PV_LSB;
      scec_pkg::REG_OUT:
        rd = 32'({q.role, 3'h0, q.direct});
      scec_pkg::REG_PID_A:
        rd = {q.ti_a, q.pb_a};
      scec_pkg::REG_PID_B:
        rd = {q.ti_b, q.pb_b};
      scec_pkg::REG_INPUT:
        rd = 32'({q.dp2, q.dp1, q.unit2, q.unit1});
      scec_pkg::REG_ALARM:
        rd = 32'({q.second_alarm_function, 4'h0, q.first_alarm_function});
      scec_pkg::REG_SETUP_ERR:
        rd = 32'(q.setup_err);
      scec_pkg::REG_COMM_ERR:
        rd = 32'(q.comm_err);
      scec_pkg::REG_IRQ_STAT:
        rd = 32'(q.irq_stat);
      scec_pkg::REG_IRQ_MASK:
        rd = 32'(q.irq_mask);
      default:
        rd = 32'h0000_0000;
    endcase
    if (q.wait_n && (i_avs_read || i_avs_write))
    begin
      d.wait_n = 1'b0;
      d.rdata = i_avs_read ? rd : 32'h0000_0000;
    end
    else if (!q.wait_n)
    begin
      d.wait_n = 1'b1;
      if (i_avs_write)
      begin
        case (i_avs_address)
          scec_pkg::REG_SRC:
          begin
            d.pv_src = i_avs_writedata[scec_pkg::SRC_PV_LSB +: 3];
            d.sp_src = i_avs_writedata[scec_pkg::SRC_SP_LSB +: 3];
          end
          scec_pkg::REG_OUT:
          begin
            d.direct = i_avs_writedata[scec_pkg::OUT_DIRECT_BIT];
            d.role = i_avs_writedata[scec_pkg::OUT_ROLE_LSB +: 2];
          end
          scec_pkg::REG_PID_A:
          begin
            d.pb_a = i_avs_writedata[scec_pkg::PID_PB_LSB +: 16];
            d.ti_a = i_avs_writedata[scec_pkg::PID_TI_LSB +: 16];
          end
          scec_pkg::REG_PID_B:
          begin
            d.pb_b = i_avs_writedata[scec_pkg::PID_PB_LSB +: 16];
            d.ti_b = i_avs_writedata[scec_pkg::PID_TI_LSB +: 16];
          end
          scec_pkg::REG_INPUT:
          begin
            d.unit1 = i_avs_writedata[scec_pkg::IN_U1_LSB +: 4];
            d.unit2 = i_avs_writedata[scec_pkg::IN_U2_LSB +: 4];
            d.dp1 = i_avs_writedata[scec_pkg::IN_DP1_LSB +: 4];
            d.dp2 = i_avs_writedata[scec_pkg::IN_DP2_LSB +: 4];
          end
          scec_pkg::REG_ALARM:
          begin
            d.first_alarm_function = i_avs_writedata[scec_pkg::ALM_A1_LSB +: 4];
            d.second_alarm_function = i_avs_writedata[scec_pkg::ALM_A2_LSB +: 4];
          end
          scec_pkg::REG_COMM_ERR:
            comm_clr = 1'b1;
          scec_pkg::REG_IRQ_STAT:
            clr_ev = i_avs_writedata[1:0];
          scec_pkg::REG_IRQ_MASK:
            d.irq_mask = i_avs_writedata[1:0];
          default:
            comm_clr = 1'b0;
        endcase
      end
    end

    // setup checks follow the parameters as they stand after this edge
    d.setup_err = check_setup(d);
    if (d.setup_err != scec_pkg::ERR_NONE && d.setup_err != q.setup_err)
      set_ev[scec_pkg::IRQ_SETUP_BIT] = 1'b1;

    // host request checking
    case (q.fsm)
      scec_pkg::SCEC_IDLE:
      begin
        if (i_req_valid && q.ready)
        begin
          d.req_write = i_req_write;
          d.req_func = i_req_func;
          d.req_addr = i_req_addr;
          d.req_data = i_req_data;
          d.ready = 1'b0;
          d.fsm = scec_pkg::SCEC_LOOKUP;
        end
      end
      scec_pkg::SCEC_LOOKUP:
        d.fsm = scec_pkg::SCEC_EVAL;
      scec_pkg::SCEC_EVAL:
      begin
        if (q.req_func != scec_pkg::FN_READ && q.req_func != scec_pkg::FN_WRITE)
          code = scec_pkg::ERR_BAD_FUNC;
        else if (q.req_addr >= scec_pkg::ADDR_LIMIT)
          code = scec_pkg::ERR_ADDR_RANGE;
        else if (!attr.present)
          code = scec_pkg::ERR_NO_PARAM;
        else if (q.req_write && attr.read_only)
          code = scec_pkg::ERR_READ_ONLY;
        else if (q.req_write && (q.req_data > attr.max_val || q.req_data < attr.min_val))
          code = scec_pkg::ERR_DATA_RANGE;
        else
          code = scec_pkg::ERR_NONE;
        d.resp_valid = 1'b1;
        d.resp_code = code;
        // refused writes never reach the parameter store
        d.wr_en = q.req_write && (code == scec_pkg::ERR_NONE);
        d.wr_addr = q.req_addr;
        d.wr_data = q.req_data;
        d.ready = 1'b1;
        d.fsm = scec_pkg::SCEC_IDLE;
        if (code != scec_pkg::ERR_NONE)
          set_ev[scec_pkg::IRQ_COMM_BIT] = 1'b1;
      end
      default:
      begin
        d.fsm = scec_pkg::SCEC_IDLE;
        d.ready = 1'b1;
      end
    endcase

    // a new comm error beats a software clear in the same cycle
    if (set_ev[scec_pkg::IRQ_COMM_BIT])
      d.comm_err = code;
    else if (comm_clr)
      d.comm_err = scec_pkg::ERR_NONE;
    d.irq_stat = (q.irq_stat & ~clr_ev) | set_ev;
    d.irq = |(d.irq_stat & d.irq_mask);

    // alarm-two role with no function leaves the output idle
    d.sec_alarm = (d.role == scec_pkg::ROLE_ALARM2) &&
                  (d.second_alarm_function != scec_pkg::ALM_NONE) && i_alarm2_trip;

    // setup faults block control, so they take the display first
    shown = (d.setup_err != scec_pkg::ERR_NONE) ? d.setup_err : d.comm_err;
    bcd = to_bcd(shown);
    d.disp_err = (shown != scec_pkg::ERR_NONE);
    d.tens = bcd[7:4];
    d.ones = bcd[3:0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      q <= '0;
      q.wait_n <= 1'b1;
      q.pv_src <= scec_pkg::RST_PV_SRC;
      q.sp_src <= scec_pkg::RST_SP_SRC;
      q.pb_a <= scec_pkg::RST_PB;
      q.ti_a <= scec_pkg::RST_TI;
      q.pb_b <= scec_pkg::RST_PB;
      q.ti_b <= scec_pkg::RST_TI;
      q.fsm <= scec_pkg::SCEC_IDLE;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = q.wait_n;
  assign o_req_ready = q.ready;
  assign o_resp_valid = q.resp_valid;
  assign o_resp_code = q.resp_code;
  assign o_wr_en = q.wr_en;
  assign o_wr_addr = q.wr_addr;
  assign o_wr_data = q.wr_data;
  assign o_secondary_alarm = q.sec_alarm;
  assign o_disp_error = q.disp_err;
  assign o_disp_tens = q.tens;
  assign o_disp_ones = q.ones;
  assign o_irq = q.irq;

endmodule

// ==== testbench/scec_checker_properties.sv ====
// port assertions for the setup and comm error checker
`timescale 1ns/1ps
module scec_checker_props (
  input logic i_clk,
  input logic i_arst_n,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic o_avs_waitrequest,
  input logic i_req_valid,
  input logic i_req_write,
  input logic [7:0] i_req_func,
  input logic [15:0] i_req_addr,
  input logic o_req_ready,
  input logic o_resp_valid,
  input logic [5:0] o_resp_code,
  input logic o_wr_en,
  input logic i_alarm2_trip,
  input logic o_secondary_alarm,
  input logic o_disp_error,
  input logic [3:0] o_disp_tens,
  input logic [3:0] o_disp_ones
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic take;
  logic fn_ok;
  assign take = i_req_valid && o_req_ready;
  assign fn_ok = i_req_func == scec_pkg::FN_READ || i_req_func == scec_pkg::FN_WRITE;
  bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer wrong");
  take_walk_a: assert property (take |=> !o_req_ready && !o_resp_valid
    ##1 !o_resp_valid ##1 o_resp_valid && o_req_ready) else $error("request walk wrong");
  resp_pulse_a: assert property (o_resp_valid |=> !o_resp_valid)
    else $error("verdict not a pulse");
  bad_func_a: assert property (take && !fn_ok |-> ##3 o_resp_code == scec_pkg::ERR_BAD_FUNC)
    else $error("bad function not flagged");
  addr_range_a: assert property (take && fn_ok && i_req_addr >= scec_pkg::ADDR_LIMIT
    |-> ##3 o_resp_code == scec_pkg::ERR_ADDR_RANGE) else $error("range not flagged");
  absent_param_a: assert property (take && fn_ok && (i_req_addr == 16'h000D
    || i_req_addr == 16'h000E) |-> ##3 o_resp_code == scec_pkg::ERR_NO_PARAM)
    else $error("absent parameter not flagged");
  ro_write_a: assert property (take && i_req_func == scec_pkg::FN_WRITE && i_req_write
    && i_req_addr inside {[16'h0030:16'h003F]}
    |-> ##3 o_resp_code == scec_pkg::ERR_READ_ONLY && !o_wr_en) else $error("ro write taken");
  wr_ok_a: assert property (o_wr_en |-> o_resp_valid && o_resp_code == scec_pkg::ERR_NONE)
    else $error("write with error");
  sec_alarm_a: assert property (o_secondary_alarm |-> $past(i_alarm2_trip))
    else $error("alarm without trip");
  disp_digits_a: assert property (o_disp_error ? (o_disp_ones <= 4'h9
    && {o_disp_tens, o_disp_ones} != 8'h00) : {o_disp_tens, o_disp_ones} == 8'h00)
    else $error("display digits wrong");
  cover property (o_wr_en);
  cover property (o_resp_valid && o_resp_code == scec_pkg::ERR_DATA_RANGE);
  cover property (o_secondary_alarm);
endmodule
bind scec_checker scec_checker_props u_props (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_func(i_req_func),
  .i_req_addr(i_req_addr), .o_req_ready(o_req_ready), .o_resp_valid(o_resp_valid),
  .o_resp_code(o_resp_code), .o_wr_en(o_wr_en), .i_alarm2_trip(i_alarm2_trip),
  .o_secondary_alarm(o_secondary_alarm), .o_disp_error(o_disp_error),
  .o_disp_tens(o_disp_tens), .o_disp_ones(o_disp_ones));

// ==== testbench/scec_host_model.sv ====
// host model issuing one request at a time on the request port
`timescale 1ns/1ps
module scec_host_model (
  input logic i_clk,
  input logic i_ready,
  input logic i_resp_valid,
  output logic o_valid,
  output logic o_write,
  output logic [7:0] o_func,
  output logic [15:0] o_addr,
  output logic [15:0] o_data
);
  initial
  begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_func = scec_pkg::FN_READ;
    o_addr = 16'h0000;
    o_data = 16'h0000;
  end
  // faulty codes and addresses only come from the bench's own calls
  task issue(input logic [7:0] f, input logic w, input logic [15:0] a, input logic [15:0] d);
    while (i_ready !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_write <= w;
    o_func <= f;
    o_addr <= a;
    o_data <= d;
    @(posedge i_clk);
    o_valid <= 1'b0;
    // released lines carry junk so a stale copy cannot pass
    o_func <= ~f;
    o_addr <= ~a;
    o_data <= ~d;
    // a missing verdict is left to the bench watchdog
    @(posedge i_clk);
    #1;
    while (i_resp_valid !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
    end
  endtask
endmodule

// ==== testbench/scec_checker_tb.sv ====
// self-checking bench for the setup and comm error checker
`timescale 1ns/1ps
module scec_checker_tb;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic i_alarm2_trip = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic o_avs_waitrequest, i_req_valid, i_req_write, o_req_ready, o_resp_valid, o_wr_en;
  logic o_secondary_alarm, o_disp_error, o_irq;
  logic [7:0] i_req_func;
  logic [15:0] i_req_addr, i_req_data, o_wr_addr, o_wr_data;
  logic [5:0] o_resp_code;
  logic [3:0] o_disp_tens, o_disp_ones;
  int mismatches = 0;
  int total_checks = 0;
  localparam logic [31:0] PID = 32'h00C80064;
  always #50 i_clk = ~i_clk;
  scec_checker dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_func(i_req_func),
    .i_req_addr(i_req_addr), .i_req_data(i_req_data), .o_req_ready(o_req_ready),
    .o_resp_valid(o_resp_valid), .o_resp_code(o_resp_code), .o_wr_en(o_wr_en),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_alarm2_trip(i_alarm2_trip),
    .o_secondary_alarm(o_secondary_alarm), .o_disp_error(o_disp_error),
    .o_disp_tens(o_disp_tens), .o_disp_ones(o_disp_ones), .o_irq(o_irq));
  scec_host_model host (.i_clk(i_clk), .i_ready(o_req_ready), .i_resp_valid(o_resp_valid),
    .o_valid(i_req_valid), .o_write(i_req_write), .o_func(i_req_func), .o_addr(i_req_addr),
    .o_data(i_req_data));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= d;
    @(posedge i_clk);
    #1;
    // no wait count is assumed; only the watchdog ends a hang
    while (o_avs_waitrequest !== 1'b0)
    begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    rd = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task disp(input logic [5:0] e);
    chk("display", {23'h0, e != 6'h00, 4'(e / 10), 4'(e % 10)},
      {23'h0, o_disp_error, o_disp_tens, o_disp_ones});
  endtask
  task cfg(input logic [31:0] s, o, p, n, a, input logic [5:0] e);
    bus(1'b1, scec_pkg::REG_SRC, s);
    bus(1'b1, scec_pkg::REG_OUT, o);
    bus(1'b1, scec_pkg::REG_PID_A, p);
    bus(1'b1, scec_pkg::REG_INPUT, n);
    bus(1'b1, scec_pkg::REG_ALARM, a);
    bus(1'b0, scec_pkg::REG_SETUP_ERR, 32'h0);
    chk("setup_err", {26'h0, e}, rd);
    disp(e);
  endtask
  task t_setup;
    cfg(32'h00, 32'h00, PID, 32'h0, 32'h0, 6'h01);
    bus(1'b1, scec_pkg::REG_SETUP_ERR, 32'h0);
    bus(1'b0, scec_pkg::REG_SETUP_ERR, 32'h0);
    chk("setup_ro", 32'h1, rd);
    bus(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, rd);
    cfg(32'h11, 32'h00, PID, 32'h0, 32'h0, 6'h02);
    cfg(32'h02, 32'h00, PID, 32'h0, 32'h0, 6'h03);
    cfg(32'h13, 32'h00, PID, 32'h0, 32'h0, 6'h03);
    cfg(32'h40, 32'h11, PID, 32'h0, 32'h0, 6'h04);
    cfg(32'h40, 32'h00, 32'h0, 32'h0, 32'h0, 6'h04);
    cfg(32'h40, 32'h00, 32'h00C80000, 32'h0, 32'h0, 6'h00);
    cfg(32'h40, 32'h00, PID, 32'h1, 32'h8, 6'h05);
    cfg(32'h42, 32'h00, PID, 32'h100, 32'h0, 6'h05);
    cfg(32'h40, 32'h20, PID, 32'h0, 32'h0, 6'h06);
    cfg(32'h40, 32'h00, PID, 32'h0, 32'h101, 6'h07);
    cfg(32'h00, 32'h00, PID, 32'h0, 32'h101, 6'h01);
    cfg(32'h40, 32'h00, PID, 32'h0, 32'h0, 6'h00);
  endtask
  task t_irq;
    bus(1'b1, scec_pkg::REG_IRQ_STAT, 32'h3);
    cfg(32'h40, 32'h20, PID, 32'h0, 32'h0, 6'h06);
    chk("irq_masked", 32'h0, {31'h0, o_irq});
    bus(1'b0, scec_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq_stat", 32'h1, rd);
    bus(1'b1, scec_pkg::REG_IRQ_MASK, 32'h1);
    bus(1'b0, scec_pkg::REG_IRQ_MASK, 32'h0);
    chk("irq_on", 32'h1, {31'h0, o_irq});
    bus(1'b1, scec_pkg::REG_IRQ_STAT, 32'h1);
    bus(1'b0, scec_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq_clear", 32'h0, {31'h0, o_irq});
  endtask
  task t_alarm;
    @(posedge i_clk);
    i_alarm2_trip <= 1'b1;
    bus(1'b0, scec_pkg::REG_SETUP_ERR, 32'h0);
    chk("alarm_off", 32'h0, {31'h0, o_secondary_alarm});
    cfg(32'h40, 32'h20, PID, 32'h0, 32'h200, 6'h00);
    chk("alarm_on", 32'h1, {31'h0, o_secondary_alarm});
  endtask
  task req(input logic [7:0] f, input logic w, input logic [15:0] a, d, input logic [5:0] e);
    host.issue(f, w, a, d);
    chk("resp_code", {26'h0, e}, {26'h0, o_resp_code});
    chk("wr_en", {31'h0, w && e == 6'h00}, {31'h0, o_wr_en});
  endtask
  task t_comm;
    req(8'h07, 1'b0, 16'h0001, 16'h0, 6'h0A);
    req(8'h07, 1'b1, 16'h0040, 16'h0, 6'h0A);
    req(scec_pkg::FN_READ, 1'b0, 16'h0040, 16'h0, 6'h0B);
    req(scec_pkg::FN_READ, 1'b0, 16'h000D, 16'h0, 6'h0C);
    req(scec_pkg::FN_WRITE, 1'b1, 16'h000E, 16'h0, 6'h0C);
    req(scec_pkg::FN_WRITE, 1'b1, 16'h0030, 16'h1, 6'h0E);
    req(scec_pkg::FN_READ, 1'b0, 16'h003F, 16'h0, 6'h00);
    req(scec_pkg::FN_WRITE, 1'b1, 16'h0007, 16'h1000, 6'h0F);
    req(scec_pkg::FN_WRITE, 1'b1, 16'h0008, 16'h2710, 6'h0F);
    disp(6'h0F);
    bus(1'b0, scec_pkg::REG_COMM_ERR, 32'h0);
    chk("comm_err", 32'hF, rd);
    bus(1'b0, scec_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq_comm", 32'h2, rd);
    req(scec_pkg::FN_WRITE, 1'b1, 16'h0008, 16'h270F, 6'h00);
    chk("wr_word", 32'h0008270F, {o_wr_addr, o_wr_data});
    req(scec_pkg::FN_WRITE, 1'b1, 16'h0007, 16'h0FFF, 6'h00);
    bus(1'b1, scec_pkg::REG_COMM_ERR, 32'h0);
    bus(1'b0, scec_pkg::REG_COMM_ERR, 32'h0);
    chk("comm_clear", 32'h0, rd);
    disp(6'h00);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_setup;
    t_irq;
    t_alarm;
    t_comm;
    test_done;
  end
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    #2000000;
    mismatches++;
    test_done;
  end
endmodule
